// file: pdcr_chan_if.sv
// signals between the control block and one channel's pointer/count logic
`timescale 1ns/100ps
`default_nettype none
interface pdcr_chan_if;
	import pdcr_pkg::*;
	logic                wr_ptr;
	logic                wr_cnt;
	logic                wr_nptr;
	logic                wr_ncnt;
	logic                step;
	logic [DATA_W-1:0]   wdata;
	pdcr_size_type       size;
	logic [PTR_W-1:0]    ptr;
	logic [CNT_W-1:0]    cnt;
	logic [PTR_W-1:0]    nptr;
	logic [CNT_W-1:0]    ncnt;
	logic                end_ev;
	logic                empty_ev;

	modport ctl (
		output wr_ptr, wr_cnt, wr_nptr, wr_ncnt, step, wdata, size,
		input  ptr, cnt, nptr, ncnt, end_ev, empty_ev
	);
	modport chan (
		input  wr_ptr, wr_cnt, wr_nptr, wr_ncnt, step, wdata, size,
		output ptr, cnt, nptr, ncnt, end_ev, empty_ev
	);
endinterface
`default_nettype wire

// file: pdcr_channel.sv
// pointer, count and next-buffer registers of one transfer direction
`timescale 1ns/100ps
`default_nettype none
module pdcr_channel (
	input  wire logic    pclk,
	input  wire logic    presetn,
	pdcr_chan_if.chan    ch
);
	import pdcr_pkg::*;

	logic [PTR_W-1:0] ptr_r;
	logic [CNT_W-1:0] cnt_r;
	logic [PTR_W-1:0] nptr_r;
	logic [CNT_W-1:0] ncnt_r;
	logic [PTR_W-1:0] ptr_nxt;
	logic [CNT_W-1:0] cnt_nxt;
	logic [PTR_W-1:0] nptr_nxt;
	logic [CNT_W-1:0] ncnt_nxt;
	logic [PTR_W-1:0] inc;
	logic             end_hit;
	logic             ncnt_zero;

	always_comb begin
		unique case (ch.size)
			PDCR_BYTE: inc = PTR_W'(1);
			PDCR_HALF: inc = PTR_W'(2);
			default:   inc = PTR_W'(4);
		endcase
	end

	always_comb begin
		ptr_nxt  = ptr_r;
		cnt_nxt  = cnt_r;
		nptr_nxt = nptr_r;
		ncnt_nxt = ncnt_r;
		if (ch.step) begin
			ptr_nxt = ptr_r + inc;
			cnt_nxt = cnt_r - CNT_W'(1);
		end
		// a software write replaces a same-cycle hardware step
		if (ch.wr_ptr)
			ptr_nxt = ch.wdata[PTR_W-1:0];
		if (ch.wr_cnt)
			cnt_nxt = ch.wdata[CNT_W-1:0];
		if (ch.wr_nptr)
			nptr_nxt = ch.wdata[PTR_W-1:0];
		if (ch.wr_ncnt)
			ncnt_nxt = ch.wdata[CNT_W-1:0];
		ncnt_zero = (ncnt_nxt == RST_COUNT);
		if (cnt_nxt == RST_COUNT && !ncnt_zero) begin
			ptr_nxt  = nptr_nxt;
			cnt_nxt  = ncnt_nxt;
			ncnt_nxt = RST_COUNT;
		end
	end

	assign end_hit     = ch.step && !ch.wr_cnt && cnt_r == CNT_W'(1);
	assign ch.end_ev   = end_hit;
	assign ch.empty_ev = end_hit && ncnt_zero;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_r  <= RST_WORD;
			cnt_r  <= RST_COUNT;
			nptr_r <= RST_WORD;
			ncnt_r <= RST_COUNT;
		end else begin
			ptr_r  <= ptr_nxt;
			cnt_r  <= cnt_nxt;
			nptr_r <= nptr_nxt;
			ncnt_r <= ncnt_nxt;
		end
	end

	assign ch.ptr  = ptr_r;
	assign ch.cnt  = cnt_r;
	assign ch.nptr = nptr_r;
	assign ch.ncnt = ncnt_r;
endmodule
`default_nettype wire

// file: pdcr_far_model.sv
// serial peripheral and memory stand-in on the far side of the channels
`timescale 1ns/100ps
`default_nettype none
module pdcr_far_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        rx_want,
	input  wire logic        tx_want,
	input  wire logic        slow,
	input  wire logic        rx_taken,
	input  wire logic        tx_load,
	input  wire logic        mem_req,
	input  wire logic [31:0] mem_addr,
	output logic             rx_ready,
	output logic             tx_ready,
	output logic      [31:0] rx_data,
	output logic             mem_ack,
	output logic      [31:0] mem_rdata
);
	logic [1:0] wait_r;
	// ready drops after each handshake so that one ready gives one move
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_ready <= 1'b0;
			tx_ready <= 1'b0;
		end else begin
			rx_ready <= rx_want & !rx_taken;
			tx_ready <= tx_want & !tx_load;
		end
	end
	// slow memory answers three cycles late; data is junk outside the answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack   <= 1'b0;
			wait_r    <= 2'h0;
			mem_rdata <= 32'h0;
		end else if (mem_req && !mem_ack && wait_r == {slow, slow}) begin
			mem_ack   <= 1'b1;
			wait_r    <= 2'h0;
			mem_rdata <= ~mem_addr;
		end else begin
			mem_ack   <= 1'b0;
			wait_r    <= wait_r + {1'b0, mem_req & !mem_ack};
			mem_rdata <= mem_rdata + 32'h1357_9BDF;
		end
	end
	assign rx_data = mem_rdata ^ 32'h5A5A_5A5A;
endmodule
`default_nettype wire

// file: pdcr_monitor.sv
// concurrent checks on the channel pair's top-level ports
`timescale 1ns/100ps
`default_nettype none
module pdcr_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic        mem_ack,
	input wire logic [31:0] mem_rdata,
	input wire logic        tx_load,
	input wire logic [31:0] tx_data,
	input wire logic        rx_taken,
	input wire logic        irq
);
	import pdcr_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic rx_en_r;
	logic tx_en_r;
	// enables rebuilt from control writes alone, independent of the design
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_en_r <= 1'b0;
			tx_en_r <= 1'b0;
		end else if (psel & penable & pready & pwrite
				& (paddr == OFF_CONTROL)) begin
			rx_en_r <= !pwdata[1] & (pwdata[0] | rx_en_r);
			tx_en_r <= !pwdata[9] & (pwdata[8] | tx_en_r);
		end
	end
	a_status_view: assert property (
		pready && !pwrite && paddr == OFF_STATUS |->
		prdata == {23'h0, tx_en_r, 7'h0, rx_en_r})
		else $error("status bits differ from enables");
	a_rx_gate: assert property ($rose(mem_req) && mem_we |->
		$past(rx_en_r) || $past(rx_en_r, 2))
		else $error("rx move while disabled");
	a_tx_gate: assert property ($rose(mem_req) && !mem_we |->
		$past(tx_en_r) || $past(tx_en_r, 2))
		else $error("tx move while disabled");
	a_tx_data: assert property (mem_req && mem_ack && !mem_we |=>
		tx_load && tx_data == $past(mem_rdata))
		else $error("tx word not handed over");
	a_rx_pulse: assert property (mem_req && mem_ack && mem_we |=>
		rx_taken ##1 !rx_taken) else $error("rx taken pulse wrong");
	a_req_hold: assert property (mem_req && !mem_ack |=>
		mem_req && $stable(mem_addr) && $stable(mem_we))
		else $error("memory request dropped or changed");
	a_req_gap: assert property ($fell(mem_req) |->
		!mem_req ##1 !mem_req) else $error("memory requests too close");
	a_irq_mask: assert property (pready && pwrite &&
		paddr == OFF_IRQ_ENA && pwdata[3:0] == 4'h0 |=> ##1 !irq)
		else $error("irq with all sources masked");
	c_tx_move: cover property (tx_load);
	c_rx_move: cover property (rx_taken);
	c_irq_up: cover property ($rose(irq));
endmodule
bind pdcr_top pdcr_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .mem_req, .mem_we, .mem_addr,
	.mem_ack, .mem_rdata, .tx_load, .tx_data, .rx_taken, .irq);
`default_nettype wire

// file: pdcr_pkg.sv
// shared constants and types for the peripheral transfer channel pair
`default_nettype none
package pdcr_pkg;
	localparam int unsigned ADDR_W   = 12;
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned PTR_W    = 32;
	localparam int unsigned CNT_W    = 16;
	localparam int unsigned IRQ_W    = 4;

	localparam logic [11:0] OFF_RX_PTR   = 12'h100;
	localparam logic [11:0] OFF_RX_CNT   = 12'h104;
	localparam logic [11:0] OFF_TX_PTR   = 12'h108;
	localparam logic [11:0] OFF_TX_CNT   = 12'h10C;
	localparam logic [11:0] OFF_RX_NPTR  = 12'h110;
	localparam logic [11:0] OFF_RX_NCNT  = 12'h114;
	localparam logic [11:0] OFF_TX_NPTR  = 12'h118;
	localparam logic [11:0] OFF_TX_NCNT  = 12'h11C;
	localparam logic [11:0] OFF_CONTROL  = 12'h120;
	localparam logic [11:0] OFF_STATUS   = 12'h124;
	localparam logic [11:0] OFF_IRQ_STS  = 12'h128;
	localparam logic [11:0] OFF_IRQ_CLR  = 12'h12C;
	localparam logic [11:0] OFF_IRQ_ENA  = 12'h130;

	localparam int unsigned CTL_RX_EN    = 0;
	localparam int unsigned CTL_RX_DIS   = 1;
	localparam int unsigned CTL_TX_EN    = 8;
	localparam int unsigned CTL_TX_DIS   = 9;
	localparam int unsigned STS_RX_EN    = 0;
	localparam int unsigned STS_TX_EN    = 8;

	localparam int unsigned IRQ_END_RX   = 0;
	localparam int unsigned IRQ_FULL_RX  = 1;
	localparam int unsigned IRQ_END_TX   = 2;
	localparam int unsigned IRQ_EMPTY_TX = 3;

	localparam logic [31:0] RST_WORD     = 32'h0000_0000;
	localparam logic [15:0] RST_COUNT    = 16'h0000;
	localparam logic [3:0]  RST_IRQ      = 4'h0;

	typedef enum logic [1:0] {
		PDCR_BYTE,
		PDCR_HALF,
		PDCR_WORD
	} pdcr_size_type;
endpackage
`default_nettype wire

// file: pdcr_top.sv
// APB register file, arbitration and memory mover for the rx/tx channel pair
//
// Function
// - transmit pointer is full 32 bits
// - 16-bit transmit count; zero stops transmit
// - 32-bit receive next pointer held
// - 16-bit receive next count held
// - 32-bit transmit next pointer held
// - 16-bit transmit next count held
// - control bit 0 enables rx unless disabled
// - control bit 1 disables rx requests
// - control bit 8 enables tx requests
// - control bit 9 disables tx requests
// - status bit 0 shows rx enabled
// - status bit 8 shows tx enabled
// - step pointer by size, decrement count
// - count zero loads next pointer and count unless next count is zero
// - next count cleared after that load
// - tx end and all-empty flags raised
`timescale 1ns/100ps
`default_nettype none
module pdcr_top (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [pdcr_pkg::ADDR_W-1:0] paddr,
	input  wire logic [pdcr_pkg::DATA_W-1:0] pwdata,
	output logic      [pdcr_pkg::DATA_W-1:0] prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    rx_ready,
	input  wire logic [pdcr_pkg::DATA_W-1:0] rx_data,
	input  wire pdcr_pkg::pdcr_size_type rx_size,
	output logic                         rx_taken,
	input  wire logic                    tx_ready,
	input  wire pdcr_pkg::pdcr_size_type tx_size,
	output logic      [pdcr_pkg::DATA_W-1:0] tx_data,
	output logic                         tx_load,
	output logic                         mem_req,
	output logic                         mem_we,
	output logic      [pdcr_pkg::PTR_W-1:0]  mem_addr,
	output pdcr_pkg::pdcr_size_type      mem_size,
	output logic      [pdcr_pkg::DATA_W-1:0] mem_wdata,
	input  wire logic                    mem_ack,
	input  wire logic [pdcr_pkg::DATA_W-1:0] mem_rdata,
	output logic                         irq
);
	import pdcr_pkg::*;

	typedef enum logic [1:0] {
		XF_IDLE,
		XF_BUSY,
		XF_GAP
	} pdcr_xfer_type;

	pdcr_chan_if rx_ch ();
	pdcr_chan_if tx_ch ();

	pdcr_channel u_rx (
		.pclk    (pclk),
		.presetn (presetn),
		.ch      (rx_ch.chan)
	);

	pdcr_channel u_tx (
		.pclk    (pclk),
		.presetn (presetn),
		.ch      (tx_ch.chan)
	);

	logic                rx_en_r;
	logic                tx_en_r;
	logic [IRQ_W-1:0]    irq_sts_r;
	logic [IRQ_W-1:0]    irq_ena_r;
	logic [IRQ_W-1:0]    irq_sts_nxt;
	logic [IRQ_W-1:0]    irq_clr;
	logic [IRQ_W-1:0]    irq_set;
	logic [DATA_W-1:0]   prdata_r;
	logic                pready_r;
	logic                pslverr_r;
	logic [DATA_W-1:0]   rd_word;
	logic                rd_hit;
	logic                wr_go;
	pdcr_xfer_type       state_r;
	logic                sel_tx_r;
	logic                mem_req_r;
	logic                mem_we_r;
	logic [PTR_W-1:0]    mem_addr_r;
	pdcr_size_type       mem_size_r;
	logic [DATA_W-1:0]   mem_wdata_r;
	logic                rx_taken_r;
	logic                tx_load_r;
	logic [DATA_W-1:0]   tx_data_r;
	logic                irq_r;
	logic                rx_go;
	logic                tx_go;
	logic                done;

	// apb: one wait state, so every access takes setup plus two cycles
	assign wr_go = psel && penable && pready_r && pwrite;

	always_comb begin
		rd_word = RST_WORD;
		rd_hit  = 1'b1;
		unique case (paddr)
			OFF_RX_PTR:  rd_word = rx_ch.ptr;
			OFF_RX_CNT:  rd_word[CNT_W-1:0] = rx_ch.cnt;
			OFF_TX_PTR:  rd_word = tx_ch.ptr;
			OFF_TX_CNT:  rd_word[CNT_W-1:0] = tx_ch.cnt;
			OFF_RX_NPTR: rd_word = rx_ch.nptr;
			OFF_RX_NCNT: rd_word[CNT_W-1:0] = rx_ch.ncnt;
			OFF_TX_NPTR: rd_word = tx_ch.nptr;
			OFF_TX_NCNT: rd_word[CNT_W-1:0] = tx_ch.ncnt;
			OFF_CONTROL: rd_word = RST_WORD;
			OFF_STATUS: begin
				rd_word[STS_RX_EN] = rx_en_r;
				rd_word[STS_TX_EN] = tx_en_r;
			end
			OFF_IRQ_STS: rd_word[IRQ_W-1:0] = irq_sts_r;
			OFF_IRQ_CLR: rd_word = RST_WORD;
			OFF_IRQ_ENA: rd_word[IRQ_W-1:0] = irq_ena_r;
			default:     rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			prdata_r  <= RST_WORD;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= psel && penable && !pready_r;
			pslverr_r <= psel && penable && !pready_r && !rd_hit;
			if (psel && penable && !pready_r && !pwrite)
				prdata_r <= rd_word;
		end
	end

	// channel register writes
	assign rx_ch.wdata   = pwdata;
	assign tx_ch.wdata   = pwdata;
	assign rx_ch.wr_ptr  = wr_go && paddr == OFF_RX_PTR;
	assign rx_ch.wr_cnt  = wr_go && paddr == OFF_RX_CNT;
	assign rx_ch.wr_nptr = wr_go && paddr == OFF_RX_NPTR;
	assign rx_ch.wr_ncnt = wr_go && paddr == OFF_RX_NCNT;
	assign tx_ch.wr_ptr  = wr_go && paddr == OFF_TX_PTR;
	assign tx_ch.wr_cnt  = wr_go && paddr == OFF_TX_CNT;
	assign tx_ch.wr_nptr = wr_go && paddr == OFF_TX_NPTR;
	assign tx_ch.wr_ncnt = wr_go && paddr == OFF_TX_NCNT;
	assign rx_ch.size    = rx_size;
	assign tx_ch.size    = tx_size;

	// enable state: disable wins on both sides
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_en_r <= 1'b0;
			tx_en_r <= 1'b0;
		end else if (wr_go && paddr == OFF_CONTROL) begin
			if (pwdata[CTL_RX_DIS])
				rx_en_r <= 1'b0;
			else if (pwdata[CTL_RX_EN])
				rx_en_r <= 1'b1;
			if (pwdata[CTL_TX_DIS])
				tx_en_r <= 1'b0;
			else if (pwdata[CTL_TX_EN])
				tx_en_r <= 1'b1;
		end
	end

	// transfer requests; receive is served before transmit
	assign rx_go = rx_en_r && rx_ready && rx_ch.cnt != RST_COUNT;
	assign tx_go = tx_en_r && tx_ready && tx_ch.cnt != RST_COUNT;
	assign done  = state_r == XF_BUSY && mem_ack;
	assign rx_ch.step = done && !sel_tx_r;
	assign tx_ch.step = done && sel_tx_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r     <= XF_IDLE;
			sel_tx_r    <= 1'b0;
			mem_req_r   <= 1'b0;
			mem_we_r    <= 1'b0;
			mem_addr_r  <= RST_WORD;
			mem_size_r  <= PDCR_BYTE;
			mem_wdata_r <= RST_WORD;
		end else begin
			unique case (state_r)
				XF_IDLE: begin
					if (rx_go) begin
						state_r     <= XF_BUSY;
						sel_tx_r    <= 1'b0;
						mem_req_r   <= 1'b1;
						mem_we_r    <= 1'b1;
						mem_addr_r  <= rx_ch.ptr;
						mem_size_r  <= rx_size;
						mem_wdata_r <= rx_data;
					end else if (tx_go) begin
						state_r    <= XF_BUSY;
						sel_tx_r   <= 1'b1;
						mem_req_r  <= 1'b1;
						mem_we_r   <= 1'b0;
						mem_addr_r <= tx_ch.ptr;
						mem_size_r <= tx_size;
					end
				end
				XF_BUSY: begin
					if (mem_ack) begin
						state_r   <= XF_GAP;
						mem_req_r <= 1'b0;
					end
				end
				// lets the peripheral drop its ready before the next look
				XF_GAP: state_r <= XF_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_taken_r <= 1'b0;
			tx_load_r  <= 1'b0;
			tx_data_r  <= RST_WORD;
		end else begin
			rx_taken_r <= rx_ch.step;
			tx_load_r  <= tx_ch.step;
			if (tx_ch.step)
				tx_data_r <= mem_rdata;
		end
	end

	// end flags: sticky, cleared by software or by a counter write
	assign irq_set[IRQ_END_RX]   = rx_ch.end_ev;
	assign irq_set[IRQ_FULL_RX]  = rx_ch.empty_ev;
	assign irq_set[IRQ_END_TX]   = tx_ch.end_ev;
	assign irq_set[IRQ_EMPTY_TX] = tx_ch.empty_ev;

	always_comb begin
		irq_clr = RST_IRQ;
		if (wr_go && paddr == OFF_IRQ_CLR)
			irq_clr = pwdata[IRQ_W-1:0];
		if (rx_ch.wr_cnt || rx_ch.wr_ncnt) begin
			irq_clr[IRQ_END_RX]  = 1'b1;
			irq_clr[IRQ_FULL_RX] = 1'b1;
		end
		if (tx_ch.wr_cnt || tx_ch.wr_ncnt) begin
			irq_clr[IRQ_END_TX]   = 1'b1;
			irq_clr[IRQ_EMPTY_TX] = 1'b1;
		end
		// a new event in the clearing cycle is kept
		irq_sts_nxt = (irq_sts_r & ~irq_clr) | irq_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_sts_r <= RST_IRQ;
			irq_ena_r <= RST_IRQ;
			irq_r     <= 1'b0;
		end else begin
			irq_sts_r <= irq_sts_nxt;
			if (wr_go && paddr == OFF_IRQ_ENA)
				irq_ena_r <= pwdata[IRQ_W-1:0];
			irq_r <= |(irq_sts_nxt & irq_ena_r);
		end
	end

	assign prdata    = prdata_r;
	assign pready    = pready_r;
	assign pslverr   = pslverr_r;
	assign rx_taken  = rx_taken_r;
	assign tx_load   = tx_load_r;
	assign tx_data   = tx_data_r;
	assign mem_req   = mem_req_r;
	assign mem_we    = mem_we_r;
	assign mem_addr  = mem_addr_r;
	assign mem_size  = mem_size_r;
	assign mem_wdata = mem_wdata_r;
	assign irq       = irq_r;
endmodule
`default_nettype wire

// file: testbench.sv
// bench for the channel pair: registers, enables, moves and interrupts
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import pdcr_pkg::*;
	typedef struct {
		logic [11:0] wa;
		logic [31:0] wd;
		logic [11:0] ra;
		logic [31:0] exp;
	} pdcr_row_type;
	logic          pclk = 1'b0;
	logic          presetn = 1'b0;
	logic          psel = 1'b0;
	logic          penable = 1'b0;
	logic          pwrite = 1'b0;
	logic [11:0]   paddr = 12'h0;
	logic [31:0]   pwdata = 32'h0;
	logic          rx_want = 1'b0;
	logic          tx_want = 1'b0;
	logic          slow = 1'b0;
	pdcr_size_type rx_size = PDCR_WORD;
	pdcr_size_type tx_size = PDCR_BYTE;
	pdcr_size_type mem_size;
	logic          pready, pslverr, rx_ready, rx_taken, tx_ready, tx_load;
	logic          mem_req, mem_we, mem_ack, irq, err;
	logic [31:0]   prdata, rx_data, tx_data, mem_addr, mem_wdata, mem_rdata;
	logic [31:0]   rd;
	logic [31:0]   last_addr = 32'h0;
	int            errors = 0;
	int            cmp_count = 0;
	int            loads = 0;
	// rx count made nonzero first, else the next-count write reloads at once
	pdcr_row_type  rows[13] = '{
		'{OFF_TX_PTR, 32'hFFFF_FFFF, OFF_TX_PTR, 32'hFFFF_FFFF},
		'{OFF_TX_CNT, 32'hFFFF_1234, OFF_TX_CNT, 32'h1234},
		'{OFF_RX_NPTR, 32'hA5A5_5A5A, OFF_RX_NPTR, 32'hA5A5_5A5A},
		'{OFF_RX_CNT, 32'h0000_0007, OFF_RX_CNT, 32'h7},
		'{OFF_RX_NCNT, 32'hFFFF_FFFF, OFF_RX_NCNT, 32'hFFFF},
		'{OFF_TX_NPTR, 32'h5A5A_A5A5, OFF_TX_NPTR, 32'h5A5A_A5A5},
		'{OFF_TX_NCNT, 32'h8000_0001, OFF_TX_NCNT, 32'h1},
		'{OFF_STATUS, 32'hFFFF_FFFF, OFF_STATUS, 32'h0},
		'{OFF_CONTROL, 32'h0101, OFF_STATUS, 32'h0101},
		'{OFF_CONTROL, 32'h0, OFF_STATUS, 32'h0101},
		'{OFF_CONTROL, 32'h0003, OFF_STATUS, 32'h0100},
		'{OFF_CONTROL, 32'h0300, OFF_STATUS, 32'h0},
		'{OFF_CONTROL, 32'h0101, OFF_CONTROL, 32'h0}};
	pdcr_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .rx_ready, .rx_data, .rx_size, .rx_taken,
		.tx_ready, .tx_size, .tx_data, .tx_load, .mem_req, .mem_we, .mem_addr,
		.mem_size, .mem_wdata, .mem_ack, .mem_rdata, .irq);
	pdcr_far_model far (.pclk, .presetn, .rx_want, .tx_want, .slow,
		.rx_taken, .tx_load, .mem_req, .mem_addr, .rx_ready, .tx_ready,
		.rx_data, .mem_ack, .mem_rdata);
	always #10 pclk = ~pclk;
	always @(posedge pclk) loads += (tx_load === 1'b1);
	always @(posedge pclk)
		if (mem_req === 1'b1) last_addr <= mem_addr;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		if (errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// entered just after a rising edge; leaves one idle edge behind it
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// pready ends this wait; the watchdog only covers a hang
		do @(posedge pclk); while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic move(input logic tx);
		tx_want <= tx;
		rx_want <= !tx;
		// room for several moves more than should come
		repeat (40) @(posedge pclk);
		tx_want <= 1'b0;
		rx_want <= 1'b0;
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[i]) begin
			apb(1'b1, rows[i].wa, rows[i].wd);
			apb(1'b0, rows[i].ra, 32'h0);
			if (i < 7) chk(rd, rows[i].exp);
			else chk(rd, rows[i].exp);
		end
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 13; i++) begin
			apb(1'b0, OFF_RX_PTR + 12'(4 * i), 32'h0);
			chk(rd, 32'h0);
		end
		apb(1'b0, 12'h200, 32'h0);
		chk({31'h0, err}, 32'h1);
		for (int s = 0; s < 3; s++) begin
			tx_size <= pdcr_size_type'(s);
			apb(1'b1, OFF_TX_PTR, 32'h1000);
			apb(1'b1, OFF_TX_CNT, 32'h2);
			apb(1'b1, OFF_CONTROL, 32'h0100);
			loads = 0;
			move(1'b1);
			chk(loads, 2);
			apb(1'b0, OFF_TX_PTR, 32'h0);
			chk(rd, 32'h1000 + (2 << s));
		end
		apb(1'b1, OFF_TX_PTR, 32'h4000);
		apb(1'b1, OFF_TX_NPTR, 32'h8000);
		apb(1'b1, OFF_TX_CNT, 32'h1);
		apb(1'b1, OFF_TX_NCNT, 32'h1);
		apb(1'b1, OFF_IRQ_ENA, 32'hC);
		move(1'b1);
		apb(1'b0, OFF_TX_NCNT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, OFF_TX_PTR, 32'h0);
		chk(rd, 32'h8004);
		chk(last_addr, 32'h8000);
		apb(1'b0, OFF_IRQ_STS, 32'h0);
		chk(rd, 32'hC);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, OFF_IRQ_ENA, 32'h0);
		@(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, OFF_IRQ_CLR, 32'hC);
		apb(1'b0, OFF_IRQ_STS, 32'h0);
		chk(rd, 32'h0);
		rx_size <= PDCR_BYTE;
		slow    <= 1'b1;
		apb(1'b1, OFF_RX_PTR, 32'h3000);
		apb(1'b1, OFF_RX_CNT, 32'h1);
		apb(1'b1, OFF_CONTROL, 32'h0001);
		move(1'b0);
		apb(1'b0, OFF_RX_PTR, 32'h0);
		chk(rd, 32'h3001);
		chk(last_addr, 32'h3000);
		chk({31'h0, mem_we}, 32'h1);
		chk({30'h0, mem_size}, 32'h0);
		end_sim();
	end
	initial begin
		#200000;
		errors++;
		end_sim();
	end
endmodule
`default_nettype wire
